// ===== logic/acp_map.svh
`ifndef ACP_MAP_SVH
`define ACP_MAP_SVH
// Word offsets on the register bus (byte addresses)
`define ACP_OFF_CTRL0      4'h0
`define ACP_OFF_CTRL1      4'h4
`define ACP_OFF_RESULT     4'h8
`define ACP_OFF_IRQ_STAT   4'hc
// Register index is the byte address bits 3:2
`define ACP_IDX_CTRL0      2'h0
`define ACP_IDX_CTRL1      2'h1
`define ACP_IDX_RESULT     2'h2
`define ACP_IDX_IRQ_STAT   2'h3
`define ACP_OFF_IRQ_MASK   5'h10
// Control register 0 fields
`define ACP_C0_ENABLE      0
`define ACP_C0_BUSY        1
`define ACP_C0_CHS_LO      2
`define ACP_C0_CHS_HI      5
`define ACP_C0_RESET       8'h00
// Control register 1 fields
`define ACP_C1_PORT_ANALOG_CONFIG_LO     0
`define ACP_C1_PORT_ANALOG_CONFIG_HI     3
`define ACP_C1_VPOS        4
`define ACP_C1_VNEG        5
`define ACP_C1_WMASK       8'h3f
`define ACP_C1_HI_RESET    3'h0
`define ACP_PORT_ANALOG_CONFIG_FUSE1     3'h0
`define ACP_PORT_ANALOG_CONFIG_FUSE0     3'h7
// Channel map
`define ACP_CHAN_LAST      4'hc
`define ACP_SMALL_GAP_LO   4'h5
`define ACP_SMALL_GAP_HI   4'h7
`define ACP_PORT_ANALOG_CONFIG_ALL_ANA   4'h2
`define ACP_NUM_CHAN       13
`define ACP_RES_BITS       10
// Converter core timing: 12 bit-times of 2 us at 125 MHz
`define ACP_CONV_TIME_NS   24000
`define ACP_CLK_NS         8
`define ACP_CONV_CYCLES    (`ACP_CONV_TIME_NS / `ACP_CLK_NS)
`endif

// ===== logic/acp_pkg.sv
package acp_pkg;
  typedef enum logic [2:0] {
    ACP_IDLE = 3'b001,
    ACP_CONV = 3'b010,
    ACP_DONE = 3'b100
  } acp_state_t;
endpackage

// ===== logic/acp_adc_ctrl.sv
`timescale 1ns/10ps
`include "acp_map.svh"
module acp_adc_ctrl #(
  parameter int unsigned CONV_CYCLES = `ACP_CONV_CYCLES
) (
  input  wire logic        mclk,            // System clock, 125 MHz
  input  wire logic        rstn,            // Async reset, active low
  input  wire logic        clk_en,          // Freezes all state when low
  input  wire logic        large_package,   // High on 13-input variant
  input  wire logic        portb_analog_fuse, // Config fuse level
  input  wire logic        wb_cyc_i,        // Wishbone cycle
  input  wire logic        wb_stb_i,        // Wishbone strobe
  input  wire logic        wb_we_i,         // Wishbone write enable
  input  wire logic [4:0]  wb_adr_i,        // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,        // Wishbone byte selects
  input  wire logic [31:0] wb_dat_i,        // Wishbone write data
  output logic      [31:0] wb_dat_o,        // Wishbone read data
  output logic             wb_ack_o,        // Wishbone acknowledge
  output logic             wb_err_o,        // Unmapped address answer
  input  wire logic [9:0]  core_result,     // Core successive-approx value
  input  wire logic [9:0]  core_float,      // Core floating-input value
  output logic      [3:0]  mux_select,      // Analog mux channel
  output logic             mux_connected,   // Mux routes a real pin
  output logic      [12:0] pin_analog,      // One per AN pin, 1 = analog
  output logic             vref_neg_pin,    // Negative ref from AN2
  output logic             vref_pos_pin,    // Positive ref from AN3
  output logic             converter_on,    // Module power enable
  output logic             irq              // Level interrupt
);
  localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

  logic [3:0]  channel_select;
  logic        converter_enable;
  logic        conv_busy;
  logic        negative_reference_select;
  logic        positive_reference_select;
  logic [3:0]  port_analog_config;
  logic [9:0]  result;
  logic        conversion_done_flag;
  logic        done_mask;
  logic [15:0] conv_cnt;
  logic        por_seen;
  acp_pkg::acp_state_t state;

  logic [3:0]  next_channel_select;
  logic        next_converter_enable;
  logic        next_conv_busy;
  logic        next_negative_reference_select;
  logic        next_positive_reference_select;
  logic [3:0]  next_port_analog_config;
  logic [9:0]  next_result;
  logic        next_conversion_done_flag;
  logic        next_done_mask;
  logic [15:0] next_conv_cnt;
  logic        next_por_seen;
  logic        next_wb_ack;
  acp_pkg::acp_state_t next_state;

  logic        bus_req;
  logic        wr_lane0;
  logic        hit_c0;
  logic        hit_c1;
  logic        hit_res;
  logic        hit_stat;
  logic        hit_mask;
  logic        chan_exists;
  logic        conv_end;
  logic [7:0]  ctrl0_rd;
  logic [7:0]  ctrl1_rd;

  assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];

  // Address decode
  always_comb
  begin
    hit_c0   = 1'b0;
    hit_c1   = 1'b0;
    hit_res  = 1'b0;
    hit_stat = 1'b0;
    hit_mask = 1'b0;
    if (wb_adr_i == {1'b0, `ACP_OFF_CTRL0})
      hit_c0 = 1'b1;
    else if (wb_adr_i == {1'b0, `ACP_OFF_CTRL1})
      hit_c1 = 1'b1;
    else if (wb_adr_i == {1'b0, `ACP_OFF_RESULT})
      hit_res = 1'b1;
    else if (wb_adr_i == {1'b0, `ACP_OFF_IRQ_STAT})
      hit_stat = 1'b1;
    else if (wb_adr_i == `ACP_OFF_IRQ_MASK)
      hit_mask = 1'b1;
  end

  always_comb
  begin
    // Codes above 12 map to nothing
    chan_exists = (channel_select <= `ACP_CHAN_LAST);
    if (!large_package && channel_select >= `ACP_SMALL_GAP_LO
        && channel_select <= `ACP_SMALL_GAP_HI)
      chan_exists = 1'b0;
  end

  // Top two bits read as zero
  assign ctrl0_rd = {2'b00, channel_select, conv_busy, converter_enable};
  assign ctrl1_rd = {2'b00, negative_reference_select,
                     positive_reference_select, port_analog_config};

  assign conv_end = (state == acp_pkg::ACP_CONV) && (conv_cnt == CONV_LAST);

  always_comb
  begin
    next_channel_select            = channel_select;
    next_converter_enable          = converter_enable;
    next_conv_busy                 = conv_busy;
    next_negative_reference_select = negative_reference_select;
    next_positive_reference_select = positive_reference_select;
    next_port_analog_config        = port_analog_config;
    next_result                    = result;
    next_conversion_done_flag      = conversion_done_flag;
    next_done_mask                 = done_mask;
    next_conv_cnt                  = conv_cnt;
    next_state                     = state;
    next_por_seen                  = 1'b1;
    next_wb_ack                    = bus_req;
    // Fuse level caught at first edge after reset release
    if (!por_seen)
      next_port_analog_config = {1'b0,
        portb_analog_fuse ? `ACP_PORT_ANALOG_CONFIG_FUSE1 : `ACP_PORT_ANALOG_CONFIG_FUSE0};
    if (wr_lane0 && hit_c0)
    begin
      next_channel_select   = wb_dat_i[`ACP_C0_CHS_HI:`ACP_C0_CHS_LO];
      next_converter_enable = wb_dat_i[`ACP_C0_ENABLE];
      // Start only when enabled and idle
      if (wb_dat_i[`ACP_C0_BUSY] && wb_dat_i[`ACP_C0_ENABLE]
          && state == acp_pkg::ACP_IDLE)
        next_conv_busy = 1'b1;
    end
    if (wr_lane0 && hit_c1)
    begin
      next_negative_reference_select = wb_dat_i[`ACP_C1_VNEG];
      next_positive_reference_select = wb_dat_i[`ACP_C1_VPOS];
      next_port_analog_config = wb_dat_i[`ACP_C1_PORT_ANALOG_CONFIG_HI:`ACP_C1_PORT_ANALOG_CONFIG_LO];
    end
    if (wr_lane0 && hit_mask)
      next_done_mask = wb_dat_i[0];
    if (wr_lane0 && hit_stat && wb_dat_i[0])
      next_conversion_done_flag = 1'b0;
    case (state)
      acp_pkg::ACP_IDLE:
        if (next_conv_busy)
        begin
          next_conv_cnt = 16'h0000;
          next_state    = acp_pkg::ACP_CONV;
        end
      acp_pkg::ACP_CONV:
        // Disabling aborts; no result, no flag
        if (!next_converter_enable)
        begin
          next_conv_busy = 1'b0;
          next_state     = acp_pkg::ACP_IDLE;
        end
        else if (conv_end)
          next_state = acp_pkg::ACP_DONE;
        else
          next_conv_cnt = conv_cnt + 16'h0001;
      acp_pkg::ACP_DONE:
      begin
        // Load result, clear busy, set flag (set beats clear)
        // Ten-bit result, floating value on missing channel
        next_result               = chan_exists ? core_result : core_float;
        next_conv_busy            = 1'b0;
        next_conversion_done_flag = 1'b1;
        next_state                = acp_pkg::ACP_IDLE;
      end
      default:
        next_state = acp_pkg::ACP_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      channel_select            <= 4'h0;
      converter_enable          <= 1'b0;
      conv_busy                 <= 1'b0;
      negative_reference_select <= 1'b0;
      positive_reference_select <= 1'b0;
      port_analog_config        <= 4'h0;
      result                    <= 10'h000;
      conversion_done_flag      <= 1'b0;
      done_mask                 <= 1'b0;
      conv_cnt                  <= 16'h0000;
      por_seen                  <= 1'b0;
      wb_ack_o                  <= 1'b0;
      state                     <= acp_pkg::ACP_IDLE;
    end
    else if (clk_en)
    begin
      channel_select            <= next_channel_select;
      converter_enable          <= next_converter_enable;
      conv_busy                 <= next_conv_busy;
      negative_reference_select <= next_negative_reference_select;
      positive_reference_select <= next_positive_reference_select;
      port_analog_config        <= next_port_analog_config;
      result                    <= next_result;
      conversion_done_flag      <= next_conversion_done_flag;
      done_mask                 <= next_done_mask;
      conv_cnt                  <= next_conv_cnt;
      por_seen                  <= next_por_seen;
      wb_ack_o                  <= next_wb_ack & hit_any();
      state                     <= next_state;
    end
  end

  function automatic logic hit_any();
    hit_any = hit_c0 | hit_c1 | hit_res | hit_stat | hit_mask;
  endfunction

  // Unmapped address answers with err, same timing as ack
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      wb_err_o <= 1'b0;
    else if (clk_en)
      wb_err_o <= bus_req & ~hit_any();
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      wb_dat_o <= 32'h0000_0000;
    else if (clk_en)
    begin
      if (bus_req && hit_c0)
        wb_dat_o <= {24'h000000, ctrl0_rd};
      else if (bus_req && hit_c1)
        wb_dat_o <= {24'h000000, ctrl1_rd};
      else if (bus_req && hit_res)
        wb_dat_o <= {22'h0, result};
      else if (bus_req && hit_stat)
        wb_dat_o <= {31'h0, conversion_done_flag};
      else if (bus_req && hit_mask)
        wb_dat_o <= {31'h0, done_mask};
    end
  end

  // Mux follows select, ignoring port config
  assign mux_select    = channel_select;
  assign mux_connected = chan_exists;

  // Thermometer of digital pins from AN12 down
  always_comb
  begin
    for (int i = 0; i < `ACP_NUM_CHAN; i++)
      pin_analog[i] = (port_analog_config <= `ACP_PORT_ANALOG_CONFIG_ALL_ANA) ||
        (4'(`ACP_NUM_CHAN - 1 - i) >=
         4'(port_analog_config - `ACP_PORT_ANALOG_CONFIG_ALL_ANA));
    if (!large_package)
      pin_analog[7:5] = 3'b000;
  end

  assign vref_neg_pin = negative_reference_select;
  assign vref_pos_pin = positive_reference_select;
  assign converter_on = converter_enable;
  assign irq          = conversion_done_flag & done_mask;

  a_busy_clear: assert property (@(posedge mclk) disable iff (!rstn)
    clk_en && state == acp_pkg::ACP_DONE |=> !conv_busy)
    else $error("busy still set after completion");
  a_done_flag: assert property (@(posedge mclk) disable iff (!rstn)
    clk_en && state == acp_pkg::ACP_DONE |=> conversion_done_flag)
    else $error("done flag not set");
  a_off_idle: assert property (@(posedge mclk) disable iff (!rstn)
    !converter_enable |-> !conv_busy)
    else $error("busy while disabled");
  a_top_zero: assert property (@(posedge mclk) disable iff (!rstn)
    wb_ack_o && (hit_c0 || hit_c1) |-> wb_dat_o[7:6] == 2'b00)
    else $error("reserved bits nonzero");
  // Small package gap channel 6 is not connected
  a_small_gap: assert property (@(posedge mclk) disable iff (!rstn)
    !large_package && channel_select == 4'h6 |-> !mux_connected)
    else $error("gap channel connected");
  a_high_code: assert property (@(posedge mclk) disable iff (!rstn)
    channel_select > `ACP_CHAN_LAST |-> !mux_connected)
    else $error("high code connected");
  a_all_dig: assert property (@(posedge mclk) disable iff (!rstn)
    port_analog_config == 4'hf |-> pin_analog == 13'h0000)
    else $error("code 15 left analog pin");
  a_por_cfg: assert property (@(posedge mclk) disable iff (!rstn)
    !por_seen && clk_en |=> port_analog_config[2:0] ==
      ($past(portb_analog_fuse) ? 3'h0 : 3'h7))
    else $error("power-on config wrong");
  a_mux_sel: assert property (@(posedge mclk) disable iff (!rstn)
    $changed(port_analog_config) && $stable(channel_select)
    |-> $stable(mux_select))
    else $error("mux moved with config");
  c_conv: cover property (@(posedge mclk) disable iff (!rstn)
    state == acp_pkg::ACP_DONE);
  c_abort: cover property (@(posedge mclk) disable iff (!rstn)
    state == acp_pkg::ACP_CONV ##1 state == acp_pkg::ACP_IDLE);
  c_irq: cover property (@(posedge mclk) disable iff (!rstn) irq);
endmodule

// ===== dv/acp_analog_model.sv
`timescale 1ns/10ps
module acp_analog_model #(
  parameter logic [9:0] FLOAT_LEVEL = 10'h2a5
) (
  input  wire logic [3:0] mux_select,    // Channel routed by the mux
  input  wire logic       mux_connected, // Mux reaches a real pin
  input  wire logic       converter_on,  // Module powered
  output logic      [9:0] core_result,   // Settled approximation
  output logic      [9:0] core_float     // Open-input reading
);
  always_comb
  begin
    core_result = {mux_select, 6'h15};
    // No pin or no power: never the clean code
    if (!mux_connected || !converter_on)
      core_result = ~core_result;
  end
  assign core_float = FLOAT_LEVEL;
endmodule

// ===== dv/acp_adc_ctrl_test.sv
`timescale 1ns/10ps
module acp_adc_ctrl_test;
  logic        mclk;
  logic        rstn;
  logic        lpkg;
  logic        fuse;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        ce;
  logic [3:0]  sel;
  logic [3:0]  wsel;
  logic [4:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        err;
  logic [9:0]  res;
  logic [9:0]  flt;
  logic [3:0]  msel;
  logic        mcon;
  logic [12:0] pin_an;
  logic        vneg;
  logic        vpos;
  logic        con;
  logic        irq;
  logic [31:0] q;
  logic        q_err;
  int          miscompares;
  int          n_checks;

  acp_adc_ctrl #(.CONV_CYCLES(8)) u_dut (
    .mclk(mclk), .rstn(rstn), .clk_en(ce), .large_package(lpkg),
    .portb_analog_fuse(fuse), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .core_result(res), .core_float(flt), .mux_select(msel),
    .mux_connected(mcon), .pin_analog(pin_an), .vref_neg_pin(vneg),
    .vref_pos_pin(vpos), .converter_on(con), .irq(irq));

  acp_analog_model u_model (
    .mux_select(msel), .mux_connected(mcon), .converter_on(con),
    .core_result(res), .core_float(flt));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until the answering edge, then releases
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= wsel;
    adr  <= a;
    wdat <= d;
    while (ack !== 1'b1 && err !== 1'b1)
    begin
      @(posedge mclk);
      n++;
      if (n > 20)
      begin
        miscompares++;
        stop_test();
      end
    end
    q = rdat;
    q_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic do_reset(input logic f);
    fuse <= f;
    rstn <= 1'b0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
  endtask

  task automatic t_reset();
    do_reset(1'b0);
    rd(5'h04);
    chk(q, 32'h07);
    rd(5'h00);
    chk(q, 32'h00);
    chk(32'(con), 32'h0);
    do_reset(1'b1);
    rd(5'h04);
    chk(q, 32'h00);
    done("reset");
  endtask

  task automatic t_regs();
    wr(5'h04, 32'hff);
    rd(5'h04);
    chk(q, 32'h3f);
    chk(32'({vneg, vpos}), 32'h3);
    wr(5'h04, 32'hdf);
    chk(32'({vneg, vpos}), 32'h1);
    wr(5'h04, 32'hcf);
    chk(32'({vneg, vpos}), 32'h0);
    // Lane 0 not selected: write must be ignored
    wsel = 4'h0;
    wr(5'h04, 32'h30);
    wsel = 4'h1;
    rd(5'h04);
    chk(q, 32'h0f);
    // Start with the module off must not begin a conversion
    wr(5'h00, 32'hfe);
    rd(5'h00);
    chk(q, 32'h3c);
    done("regs");
  endtask

  task automatic t_port_analog_config();
    for (int c = 0; c < 16; c++)
    begin
      wr(5'h04, 32'(c));
      chk(32'(pin_an), 32'(13'h1fff >> (c < 3 ? 0 : c - 2)));
    end
    lpkg <= 1'b0;
    wr(5'h04, 32'h0);
    chk(32'(pin_an), 32'h1f1f);
    lpkg <= 1'b1;
    done("port_analog_config");
  endtask

  task automatic t_chan();
    logic conn;
    wr(5'h04, 32'h0f);
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 16; c++)
      begin
        lpkg <= p[0];
        wr(5'h00, 32'(c << 2));
        chk(32'(msel), 32'(c));
        conn = (c <= 12) && !(p == 0 && c >= 5 && c <= 7);
        chk(32'(mcon), 32'(conn));
      end
    lpkg <= 1'b1;
    done("chan");
  endtask

  task automatic t_conv(input logic [3:0] ch, input logic p, input logic m);
    int n;
    logic [9:0] exp;
    n = 0;
    exp = (ch <= 4'hc && !(!p && ch >= 4'h5 && ch <= 4'h7)) ?
          {ch, 6'h15} : 10'h2a5;
    lpkg <= p;
    wr(5'h10, 32'(m));
    wr(5'h00, 32'({ch, 2'b11}));
    chk(32'(con), 32'h1);
    rd(5'h00);
    chk(32'(q[1]), 32'h1);
    while (q[1] === 1'b1 && n < 40)
    begin
      rd(5'h00);
      n++;
    end
    if (n >= 40)
    begin
      miscompares++;
      stop_test();
    end
    chk(q, 32'({ch, 2'b01}));
    rd(5'h08);
    chk(q, 32'(exp));
    chk(32'(irq), 32'(m));
    rd(5'h0c);
    chk(q, 32'h1);
    wr(5'h0c, 32'h1);
    chk(32'(irq), 32'h0);
    done("conv");
  endtask

  // Clock enable low must stall a running conversion
  task automatic t_freeze();
    wr(5'h00, 32'h07);
    ce <= 1'b0;
    repeat (20) @(posedge mclk);
    ce <= 1'b1;
    rd(5'h00);
    chk(q, 32'h07);
    repeat (12) @(posedge mclk);
    rd(5'h00);
    chk(q, 32'h05);
    rd(5'h0c);
    chk(q, 32'h1);
    chk(32'(irq), 32'h1);
    wr(5'h0c, 32'h1);
    done("freeze");
  endtask

  task automatic t_abort();
    wr(5'h00, 32'h0b);
    wr(5'h00, 32'h0a);
    rd(5'h00);
    chk(q, 32'h08);
    chk(32'(con), 32'h0);
    repeat (20) @(posedge mclk);
    rd(5'h0c);
    chk(q, 32'h0);
    bus(1'b0, 5'h14, 32'h0);
    chk(32'(q_err), 32'h1);
    done("abort");
  endtask

  initial
  begin
    rstn = 1'b0;
    lpkg = 1'b1;
    fuse = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    ce = 1'b1;
    sel = 4'h1;
    wsel = 4'h1;
    adr = 5'h00;
    wdat = 32'h0;
    miscompares = 0;
    n_checks = 0;
    t_reset();
    t_regs();
    t_port_analog_config();
    t_chan();
    t_conv(4'h3, 1'b1, 1'b1);
    t_conv(4'hd, 1'b1, 1'b1);
    t_conv(4'h6, 1'b0, 1'b0);
    t_conv(4'hc, 1'b1, 1'b1);
    t_freeze();
    t_abort();
    stop_test();
  end
endmodule
